// ===== common/sclk_pkg.sv
// Shared constants for the system clock select and crystal fail detect block
package sclk_pkg;

  // Register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CLK_SEL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DET_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DET_STS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TICK_CSR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_OSC_CTL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OSC_STS = 8'h14;

  // clock_select_reg_0 fields
  localparam int SYS_SEL_LSB = 0;
  localparam int TICK_SEL_LSB = 3;
  localparam int SEL_W = 3;
  // clock_detect_control_reg fields
  localparam int FAST_DET_EN_BIT = 4;
  localparam int FAST_IRQ_EN_BIT = 5;
  localparam int SLOW_DET_EN_BIT = 12;
  localparam int SLOW_IRQ_EN_BIT = 13;
  // clock_detect_status_reg fields
  localparam int FAST_FAIL_BIT = 0;
  localparam int SLOW_FAIL_BIT = 1;
  // tick_timer_ctrl_status field
  localparam int TICK_CPU_BIT = 2;
  // Oscillator control / status fields
  localparam int FAST_XTAL_EN_BIT = 0;
  localparam int SLOW_XTAL_EN_BIT = 1;
  localparam int FAST_RC_EN_BIT = 2;
  localparam int SLOW_RC_EN_BIT = 3;
  localparam int PLL_EN_BIT = 4;
  localparam int PLL_SRC_RC_BIT = 8;
  localparam int FAST_STABLE_BIT = 0;
  localparam int SLOW_STABLE_BIT = 1;
  localparam int CUR_SRC_LSB = 4;

  // Reset values
  localparam logic [31:0] RST_CLK_SEL0 = 32'h0000_003F;
  localparam logic [31:0] RST_DET_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_TICK_CSR = 32'h0000_0004;
  localparam logic [31:0] RST_OSC_CTL = 32'h0000_0004;

  // System clock source codes
  localparam logic [2:0] SYS_FAST_XTAL = 3'h0;
  localparam logic [2:0] SYS_SLOW_XTAL = 3'h1;
  localparam logic [2:0] SYS_PLL = 3'h2;
  localparam logic [2:0] SYS_SLOW_RC = 3'h3;
  localparam logic [2:0] SYS_USB_RC = 3'h5;
  localparam logic [2:0] SYS_FAST_RC = 3'h7;
  // Tick reference source codes
  localparam logic [2:0] TICK_FAST_XTAL = 3'h0;
  localparam logic [2:0] TICK_SLOW_XTAL = 3'h1;
  localparam logic [2:0] TICK_FAST_XTAL_DIV2 = 3'h2;
  localparam logic [2:0] TICK_SYS_DIV2 = 3'h3;
  localparam logic [2:0] TICK_FAST_RC_DIV2 = 3'h7;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int FAIL_TIMEOUT_NS = 1000;
  localparam int FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int STABLE_EDGES = 16;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_ARM
  } sclk_sw_state_t;

endpackage

// ===== logic/sclk_ctrl.sv
// System clock and tick reference selection with crystal fail detection
//
// Behaviour
// - System clock from six sources, 3-bit select
// - Two fail detectors, own enables and interrupts
// - Fast detector enabled turns fast RC on
// - Slow detector enabled turns slow RC on
// - Fast crystal stop switches system to fast RC
// - Fast crystal stop sets fail flag bit 0
// - Fast fail interrupt only when enable bit 5 set, slow fail interrupt only when bit 13 set
// - Stable indication set only once crystal oscillates
// - Tick clock from CPU or external reference
// - External tick reference among five sources
// - Tick reference select in bits 5:3
//
// Added by the designer: strobed register access and the placing of the registers.
module sclk_ctrl #(
  parameter int TIMEOUT_CYC = sclk_pkg::FAIL_TIMEOUT_CYC,
  parameter int STABLE_EDGES = sclk_pkg::STABLE_EDGES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [sclk_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Oscillator levels, sampled on sys_clk
  input wire logic fast_crystal_osc,
  input wire logic slow_crystal_osc,
  input wire logic fast_internal_rc,
  input wire logic slow_internal_rc,
  input wire logic usb_internal_rc,
  input wire logic pll_clk,
  // Oscillator enables
  output logic fast_crystal_en,
  output logic slow_crystal_en,
  output logic fast_rc_en,
  output logic slow_rc_en,
  output logic pll_en,
  output logic pll_src_rc,
  // Clock results
  output logic sys_clk_out,
  output logic tick_clk_out,
  // Interrupt
  output logic clk_fail_irq
);

  initial begin
    if (TIMEOUT_CYC < 2 || STABLE_EDGES < 1) begin
      $error("sclk_ctrl: bad timing parameters");
    end
  end

  localparam int SEL_W = sclk_pkg::SEL_W;

  // Registers
  logic [SEL_W-1:0] sys_clk_src_sel_ff;
  logic [SEL_W-1:0] tick_ref_src_sel_ff;
  logic fast_det_en_ff;
  logic slow_det_en_ff;
  logic fast_xtal_fail_irq_en_ff;
  logic slow_fail_irq_en_ff;
  logic fast_xtal_fail_flag_ff;
  logic slow_fail_flag_ff;
  logic tick_from_cpu_ff;
  logic fast_xtal_en_ff;
  logic slow_xtal_en_ff;
  logic fast_rc_sw_en_ff;
  logic slow_rc_sw_en_ff;
  logic pll_en_ff;
  logic pll_src_rc_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic fast_rc_out_ff;
  logic slow_rc_out_ff;
  logic tick_out_ff;
  logic fast_div2_ff;
  logic sys_div2_ff;
  logic rc_div2_ff;
  logic fast_prev_ff;
  logic sys_prev_ff;
  logic rc_prev_ff;

  // Internal wires
  logic fast_stable;
  logic slow_stable;
  logic fast_fail;
  logic slow_fail;
  logic auto_switch;
  logic [SEL_W-1:0] sys_cur;
  logic [7:0] sys_levels;
  logic mux_out;
  logic wr_sel0;
  logic wr_ctl;
  logic rd_sts;
  logic tick_ref_level;
  logic [31:0] nxt_rdata;

  // Register address match, shared by all write and read paths
  function automatic logic hit(input logic [sclk_pkg::ADDR_W-1:0] a,
                               input logic [sclk_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Codes outside the six documented sources are treated as the fast RC
  function automatic logic [SEL_W-1:0] legal_sys(input logic [SEL_W-1:0] code);
    case (code)
      sclk_pkg::SYS_FAST_XTAL,
      sclk_pkg::SYS_SLOW_XTAL,
      sclk_pkg::SYS_PLL,
      sclk_pkg::SYS_SLOW_RC,
      sclk_pkg::SYS_USB_RC: legal_sys = code;
      default: legal_sys = sclk_pkg::SYS_FAST_RC;
    endcase
  endfunction

  assign wr_sel0 = reg_wr && hit(reg_addr, sclk_pkg::OFF_CLK_SEL0);
  assign wr_ctl = reg_wr && hit(reg_addr, sclk_pkg::OFF_DET_CTL);
  assign rd_sts = reg_rd && hit(reg_addr, sclk_pkg::OFF_DET_STS);

  // Crystal driving the system clock, directly or through the PLL
  assign auto_switch = fast_fail && fast_det_en_ff &&
    ((sys_cur == sclk_pkg::SYS_FAST_XTAL) ||
     ((sys_cur == sclk_pkg::SYS_PLL) && !pll_src_rc_ff));

  // Fail detectors
  sclk_fail_det #(
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .STABLE_EDGES(STABLE_EDGES)
  ) u_fast_det (
    .sys_clk(sys_clk),
    .reset(reset),
    .osc_level(fast_crystal_osc),
    .osc_en(fast_xtal_en_ff),
    .det_en(fast_det_en_ff),
    .stable(fast_stable),
    .fail_pulse(fast_fail)
  );

  sclk_fail_det #(
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .STABLE_EDGES(STABLE_EDGES)
  ) u_slow_det (
    .sys_clk(sys_clk),
    .reset(reset),
    .osc_level(slow_crystal_osc),
    .osc_en(slow_xtal_en_ff),
    .det_en(slow_det_en_ff),
    .stable(slow_stable),
    .fail_pulse(slow_fail)
  );

  // Six sources on their select codes; unused codes carry the fast RC
  always_comb begin
    sys_levels = {8{fast_internal_rc}};
    sys_levels[sclk_pkg::SYS_FAST_XTAL] = fast_crystal_osc;
    sys_levels[sclk_pkg::SYS_SLOW_XTAL] = slow_crystal_osc;
    sys_levels[sclk_pkg::SYS_PLL] = pll_clk;
    sys_levels[sclk_pkg::SYS_SLOW_RC] = slow_internal_rc;
    sys_levels[sclk_pkg::SYS_USB_RC] = usb_internal_rc;
  end

  sclk_glitch_mux #(
    .NSRC(8)
  ) u_sys_mux (
    .sys_clk(sys_clk),
    .reset(reset),
    .src_level(sys_levels),
    .sel(sys_clk_src_sel_ff),
    .force_now(auto_switch),
    .clk_out(mux_out),
    .cur_sel(sys_cur)
  );

  assign sys_clk_out = mux_out;

  // clock_select_reg_0; hardware fallback overrides a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sys_clk_src_sel_ff <= sclk_pkg::RST_CLK_SEL0[sclk_pkg::SYS_SEL_LSB +: SEL_W];
      tick_ref_src_sel_ff <= sclk_pkg::RST_CLK_SEL0[sclk_pkg::TICK_SEL_LSB +: SEL_W];
    end else begin
      if (wr_sel0) begin
        sys_clk_src_sel_ff <= legal_sys(reg_wdata[sclk_pkg::SYS_SEL_LSB +: SEL_W]);
        tick_ref_src_sel_ff <= reg_wdata[sclk_pkg::TICK_SEL_LSB +: SEL_W];
      end
      if (auto_switch) begin
        sys_clk_src_sel_ff <= sclk_pkg::SYS_FAST_RC;
      end
    end
  end

  // clock_detect_control_reg
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_det_en_ff <= sclk_pkg::RST_DET_CTL[sclk_pkg::FAST_DET_EN_BIT];
      fast_xtal_fail_irq_en_ff <= sclk_pkg::RST_DET_CTL[sclk_pkg::FAST_IRQ_EN_BIT];
      slow_det_en_ff <= sclk_pkg::RST_DET_CTL[sclk_pkg::SLOW_DET_EN_BIT];
      slow_fail_irq_en_ff <= sclk_pkg::RST_DET_CTL[sclk_pkg::SLOW_IRQ_EN_BIT];
    end else if (wr_ctl) begin
      fast_det_en_ff <= reg_wdata[sclk_pkg::FAST_DET_EN_BIT];
      fast_xtal_fail_irq_en_ff <= reg_wdata[sclk_pkg::FAST_IRQ_EN_BIT];
      slow_det_en_ff <= reg_wdata[sclk_pkg::SLOW_DET_EN_BIT];
      slow_fail_irq_en_ff <= reg_wdata[sclk_pkg::SLOW_IRQ_EN_BIT];
    end
  end

  // Sticky fail flags, cleared by reading; a new failure beats the clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_xtal_fail_flag_ff <= 1'b0;
      slow_fail_flag_ff <= 1'b0;
    end else begin
      if (fast_fail) begin
        fast_xtal_fail_flag_ff <= 1'b1;
      end else if (rd_sts) begin
        fast_xtal_fail_flag_ff <= 1'b0;
      end
      if (slow_fail) begin
        slow_fail_flag_ff <= 1'b1;
      end else if (rd_sts) begin
        slow_fail_flag_ff <= 1'b0;
      end
    end
  end

  // Level interrupt while an enabled flag stands
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (fast_xtal_fail_flag_ff && fast_xtal_fail_irq_en_ff) ||
                (slow_fail_flag_ff && slow_fail_irq_en_ff);
    end
  end

  assign clk_fail_irq = irq_ff;

  // tick_timer_ctrl_status source bit and oscillator controls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_from_cpu_ff <= sclk_pkg::RST_TICK_CSR[sclk_pkg::TICK_CPU_BIT];
    end else if (reg_wr && hit(reg_addr, sclk_pkg::OFF_TICK_CSR)) begin
      tick_from_cpu_ff <= reg_wdata[sclk_pkg::TICK_CPU_BIT];
    end
  end

  // Crystal may be dropped and re-enabled to retry it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_xtal_en_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::FAST_XTAL_EN_BIT];
      slow_xtal_en_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::SLOW_XTAL_EN_BIT];
      fast_rc_sw_en_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::FAST_RC_EN_BIT];
      slow_rc_sw_en_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::SLOW_RC_EN_BIT];
      pll_en_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::PLL_EN_BIT];
      pll_src_rc_ff <= sclk_pkg::RST_OSC_CTL[sclk_pkg::PLL_SRC_RC_BIT];
    end else if (reg_wr && hit(reg_addr, sclk_pkg::OFF_OSC_CTL)) begin
      fast_xtal_en_ff <= reg_wdata[sclk_pkg::FAST_XTAL_EN_BIT];
      slow_xtal_en_ff <= reg_wdata[sclk_pkg::SLOW_XTAL_EN_BIT];
      fast_rc_sw_en_ff <= reg_wdata[sclk_pkg::FAST_RC_EN_BIT];
      slow_rc_sw_en_ff <= reg_wdata[sclk_pkg::SLOW_RC_EN_BIT];
      pll_en_ff <= reg_wdata[sclk_pkg::PLL_EN_BIT];
      pll_src_rc_ff <= reg_wdata[sclk_pkg::PLL_SRC_RC_BIT];
    end
  end

  assign fast_crystal_en = fast_xtal_en_ff;
  assign slow_crystal_en = slow_xtal_en_ff;
  assign pll_en = pll_en_ff;
  assign pll_src_rc = pll_src_rc_ff;

  // RC oscillators forced on by their detector, so the fallback is always ready
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_rc_out_ff <= 1'b1;
      slow_rc_out_ff <= 1'b0;
    end else begin
      fast_rc_out_ff <= fast_rc_sw_en_ff || fast_det_en_ff;
      slow_rc_out_ff <= slow_rc_sw_en_ff || slow_det_en_ff;
    end
  end

  assign fast_rc_en = fast_rc_out_ff;
  assign slow_rc_en = slow_rc_out_ff;

  // Divide-by-two references toggle on rising edges of their source
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_prev_ff <= 1'b0;
      sys_prev_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
      fast_div2_ff <= 1'b0;
      sys_div2_ff <= 1'b0;
      rc_div2_ff <= 1'b0;
    end else begin
      fast_prev_ff <= fast_crystal_osc;
      sys_prev_ff <= mux_out;
      rc_prev_ff <= fast_internal_rc;
      fast_div2_ff <= fast_div2_ff ^ (fast_crystal_osc && !fast_prev_ff);
      sys_div2_ff <= sys_div2_ff ^ (mux_out && !sys_prev_ff);
      rc_div2_ff <= rc_div2_ff ^ (fast_internal_rc && !rc_prev_ff);
    end
  end

  // Five external tick references; other codes give a quiet low reference
  always_comb begin
    case (tick_ref_src_sel_ff)
      sclk_pkg::TICK_FAST_XTAL: tick_ref_level = fast_crystal_osc;
      sclk_pkg::TICK_SLOW_XTAL: tick_ref_level = slow_crystal_osc;
      sclk_pkg::TICK_FAST_XTAL_DIV2: tick_ref_level = fast_div2_ff;
      sclk_pkg::TICK_SYS_DIV2: tick_ref_level = sys_div2_ff;
      sclk_pkg::TICK_FAST_RC_DIV2: tick_ref_level = rc_div2_ff;
      default: tick_ref_level = 1'b0;
    endcase
  end

  // Tick clock from CPU clock or the chosen external reference
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_out_ff <= 1'b0;
    end else begin
      tick_out_ff <= tick_from_cpu_ff ? mux_out : tick_ref_level;
    end
  end

  assign tick_clk_out = tick_out_ff;

  // Read data; stable bits tell software when the crystal may be reselected
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(reg_addr, sclk_pkg::OFF_CLK_SEL0)) begin
      nxt_rdata[sclk_pkg::SYS_SEL_LSB +: SEL_W] = sys_clk_src_sel_ff;
      nxt_rdata[sclk_pkg::TICK_SEL_LSB +: SEL_W] = tick_ref_src_sel_ff;
    end else if (hit(reg_addr, sclk_pkg::OFF_DET_CTL)) begin
      nxt_rdata[sclk_pkg::FAST_DET_EN_BIT] = fast_det_en_ff;
      nxt_rdata[sclk_pkg::FAST_IRQ_EN_BIT] = fast_xtal_fail_irq_en_ff;
      nxt_rdata[sclk_pkg::SLOW_DET_EN_BIT] = slow_det_en_ff;
      nxt_rdata[sclk_pkg::SLOW_IRQ_EN_BIT] = slow_fail_irq_en_ff;
    end else if (hit(reg_addr, sclk_pkg::OFF_DET_STS)) begin
      nxt_rdata[sclk_pkg::FAST_FAIL_BIT] = fast_xtal_fail_flag_ff;
      nxt_rdata[sclk_pkg::SLOW_FAIL_BIT] = slow_fail_flag_ff;
    end else if (hit(reg_addr, sclk_pkg::OFF_TICK_CSR)) begin
      nxt_rdata[sclk_pkg::TICK_CPU_BIT] = tick_from_cpu_ff;
    end else if (hit(reg_addr, sclk_pkg::OFF_OSC_CTL)) begin
      nxt_rdata[sclk_pkg::FAST_XTAL_EN_BIT] = fast_xtal_en_ff;
      nxt_rdata[sclk_pkg::SLOW_XTAL_EN_BIT] = slow_xtal_en_ff;
      nxt_rdata[sclk_pkg::FAST_RC_EN_BIT] = fast_rc_sw_en_ff;
      nxt_rdata[sclk_pkg::SLOW_RC_EN_BIT] = slow_rc_sw_en_ff;
      nxt_rdata[sclk_pkg::PLL_EN_BIT] = pll_en_ff;
      nxt_rdata[sclk_pkg::PLL_SRC_RC_BIT] = pll_src_rc_ff;
    end else if (hit(reg_addr, sclk_pkg::OFF_OSC_STS)) begin
      nxt_rdata[sclk_pkg::FAST_STABLE_BIT] = fast_stable;
      nxt_rdata[sclk_pkg::SLOW_STABLE_BIT] = slow_stable;
      nxt_rdata[sclk_pkg::CUR_SRC_LSB +: SEL_W] = sys_cur;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// ===== logic/sclk_fail_det.sv
// Oscillator activity watcher: stable indication and stop detection
module sclk_fail_det #(
  parameter int TIMEOUT_CYC = sclk_pkg::FAIL_TIMEOUT_CYC,
  parameter int STABLE_EDGES = sclk_pkg::STABLE_EDGES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Oscillator side
  input wire logic osc_level,
  input wire logic osc_en,
  input wire logic det_en,
  // Results
  output logic stable,
  output logic fail_pulse
);

  initial begin
    if (TIMEOUT_CYC < 2 || STABLE_EDGES < 1) begin
      $error("sclk_fail_det: bad parameters");
    end
  end

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam int EW = $clog2(STABLE_EDGES + 1);

  logic prev_ff;
  logic [CW-1:0] idle_ff;
  logic [EW-1:0] edges_ff;
  logic stable_ff;
  logic fail_ff;
  logic rise;

  assign rise = osc_level && !prev_ff;
  assign stable = stable_ff;
  assign fail_pulse = fail_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= osc_level;
    end
  end

  // Idle counter restarts on every rising edge of the oscillator
  always_ff @(posedge sys_clk) begin
    if (reset || rise || !osc_en) begin
      idle_ff <= '0;
    end else if (idle_ff != CW'(TIMEOUT_CYC)) begin
      idle_ff <= idle_ff + 1'b1;
    end
  end

  // Stable only after enough edges since the oscillator was enabled
  always_ff @(posedge sys_clk) begin
    if (reset || !osc_en) begin
      edges_ff <= '0;
      stable_ff <= 1'b0;
    end else if (idle_ff == CW'(TIMEOUT_CYC)) begin
      edges_ff <= '0;
      stable_ff <= 1'b0;
    end else if (rise && !stable_ff) begin
      edges_ff <= edges_ff + 1'b1;
      stable_ff <= (edges_ff == EW'(STABLE_EDGES - 1));
    end
  end

  // One pulse when a running, detected oscillator goes quiet; disabling it is no failure
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fail_ff <= 1'b0;
    end else begin
      fail_ff <= det_en && osc_en && stable_ff && (idle_ff == CW'(TIMEOUT_CYC - 1));
    end
  end

endmodule

// ===== logic/sclk_glitch_mux.sv
// Glitch-free switch between sampled source clock levels
module sclk_glitch_mux #(
  parameter int NSRC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Sources and selection
  input wire logic [NSRC-1:0] src_level,
  input wire logic [$clog2(NSRC)-1:0] sel,
  input wire logic force_now,
  // Result
  output logic clk_out,
  output logic [$clog2(NSRC)-1:0] cur_sel
);

  initial begin
    if (NSRC < 2) begin
      $error("sclk_glitch_mux: NSRC too small");
    end
  end

  localparam int SW = $clog2(NSRC);

  sclk_pkg::sclk_sw_state_t state_ff;
  logic [SW-1:0] cur_ff;
  logic out_ff;
  logic force_ff;

  assign clk_out = out_ff;
  assign cur_sel = cur_ff;

  // Fallback request is one cycle wide and may come before the mux drains
  always_ff @(posedge sys_clk) begin
    if (reset || state_ff == sclk_pkg::SW_DRAIN) begin
      force_ff <= 1'b0;
    end else if (force_now) begin
      force_ff <= 1'b1;
    end
  end

  // Old source is left while low or on a forced change, new one joins only while low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= sclk_pkg::SW_ARM;
      cur_ff <= SW'(NSRC - 1);
      out_ff <= 1'b0;
    end else begin
      case (state_ff)
        sclk_pkg::SW_RUN: begin
          out_ff <= src_level[cur_ff];
          if (sel != cur_ff) begin
            state_ff <= sclk_pkg::SW_DRAIN;
          end
        end
        sclk_pkg::SW_DRAIN: begin
          // A stopped source may hang high, so a forced change just parks low
          if (!src_level[cur_ff] || force_now || force_ff) begin
            out_ff <= 1'b0;
            cur_ff <= sel;
            state_ff <= sclk_pkg::SW_ARM;
          end else begin
            out_ff <= src_level[cur_ff];
          end
        end
        sclk_pkg::SW_ARM: begin
          out_ff <= 1'b0;
          if (!src_level[cur_ff]) begin
            state_ff <= sclk_pkg::SW_RUN;
          end
        end
        default: begin
          state_ff <= sclk_pkg::SW_ARM;
          out_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== sim/sclk_ctrl_checker.sv
// Port assertions for the clock select and fail detect block
module sclk_ctrl_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [sclk_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Results
  input wire logic fast_rc_en,
  input wire logic slow_rc_en,
  input wire logic sys_clk_out,
  input wire logic tick_clk_out,
  input wire logic clk_fail_irq
);
  logic fdet_ff, sdet_ff, irqen_ff, tcpu_ff, rd_sts;
  logic [2:0] tsel_ff;
  assign rd_sts = reg_rd && reg_addr == sclk_pkg::OFF_DET_STS;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadow of software control bits
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fdet_ff <= 1'b0;
      sdet_ff <= 1'b0;
      irqen_ff <= 1'b0;
      tcpu_ff <= 1'b1;
      tsel_ff <= 3'h7;
    end else if (reg_wr && reg_addr == sclk_pkg::OFF_DET_CTL) begin
      fdet_ff <= reg_wdata[sclk_pkg::FAST_DET_EN_BIT];
      sdet_ff <= reg_wdata[sclk_pkg::SLOW_DET_EN_BIT];
      irqen_ff <= reg_wdata[sclk_pkg::FAST_IRQ_EN_BIT] | reg_wdata[sclk_pkg::SLOW_IRQ_EN_BIT];
    end else if (reg_wr && reg_addr == sclk_pkg::OFF_CLK_SEL0) begin
      tsel_ff <= reg_wdata[5:3];
    end else if (reg_wr && reg_addr == sclk_pkg::OFF_TICK_CSR) begin
      tcpu_ff <= reg_wdata[sclk_pkg::TICK_CPU_BIT];
    end
  end
  sequence wr_rd(off);
    reg_wr && reg_addr == off ##1 reg_rd && reg_addr == off;
  endsequence
  a_sys_sel_back: assert property (wr_rd(sclk_pkg::OFF_CLK_SEL0) |=>
    reg_rdata[2:0] == (($past(reg_wdata[2:0], 2) inside {3'h4, 3'h6}) ? 3'h7
    : $past(reg_wdata[2:0], 2))) else $error("system select readback wrong");
  a_tick_sel_back: assert property (wr_rd(sclk_pkg::OFF_CLK_SEL0) |=>
    reg_rdata[5:3] == $past(reg_wdata[5:3], 2)) else $error("tick select readback wrong");
  a_fast_rc_on: assert property (fdet_ff |=> fast_rc_en)
    else $error("fast rc off with detector on");
  a_slow_rc_on: assert property (sdet_ff |=> slow_rc_en)
    else $error("slow rc off with detector on");
  a_irq_needs_en: assert property (clk_fail_irq |-> $past(irqen_ff))
    else $error("interrupt without enable");
  a_irq_read_clr: assert property (rd_sts |-> ##2 !clk_fail_irq)
    else $error("interrupt survives status read");
  a_irq_holds: assert property (clk_fail_irq && irqen_ff && !rd_sts && !$past(rd_sts)
    |=> clk_fail_irq) else $error("interrupt dropped early");
  a_tick_off: assert property ((!tcpu_ff && tsel_ff inside {3'h4, 3'h5, 3'h6}) [*3]
    |-> !tick_clk_out) else $error("tick active on unused code");
  // A one-cycle high pulse would be a shortened clock
  a_no_short_high: assert property ($rose(sys_clk_out) |=> sys_clk_out)
    else $error("short system clock pulse");
endmodule

bind sclk_ctrl sclk_ctrl_checker u_chk (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en), .sys_clk_out(sys_clk_out),
  .tick_clk_out(tick_clk_out), .clk_fail_irq(clk_fail_irq));

// ===== sim/test_sclk_ctrl.sv
// Self-checking bench for the clock select and fail detect block
module test_sclk_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [sclk_pkg::ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fast_crystal_osc = 1'b0, slow_crystal_osc = 1'b0, fast_internal_rc = 1'b0;
  logic slow_internal_rc = 1'b0, usb_internal_rc = 1'b0, pll_clk = 1'b0, stop_fast = 1'b0;
  logic [31:0] reg_rdata, v;
  logic fast_rc_en, slow_rc_en, sys_clk_out, tick_clk_out, clk_fail_irq, fast_crystal_en, pll_en;
  logic [3:0] cnt = 4'h0;
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [31:0] ROWS [7][2] = '{'{32'h0000_0009, 32'h0000_0009},
    '{32'h0000_0012, 32'h0000_0012}, '{32'h0000_001B, 32'h0000_001B},
    '{32'h0000_0004, 32'h0000_0007}, '{32'h0000_0035, 32'h0000_0035},
    '{32'h0000_0026, 32'h0000_0027}, '{32'h0000_003F, 32'h0000_003F}};
  always #5 sys_clk = ~sys_clk;
  // Sources toggle at most every second cycle so each edge is seen
  always @(posedge sys_clk) begin
    cnt <= cnt + 4'h1;
    fast_crystal_osc <= cnt[1] & ~stop_fast;
    slow_crystal_osc <= cnt[3];
    fast_internal_rc <= cnt[1];
    slow_internal_rc <= cnt[2];
    usb_internal_rc <= cnt[1];
    pll_clk <= cnt[2];
  end
  sclk_ctrl #(.TIMEOUT_CYC(8), .STABLE_EDGES(2)) dut (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fast_crystal_osc(fast_crystal_osc),
    .slow_crystal_osc(slow_crystal_osc), .fast_internal_rc(fast_internal_rc),
    .slow_internal_rc(slow_internal_rc), .usb_internal_rc(usb_internal_rc), .pll_clk(pll_clk),
    .fast_crystal_en(fast_crystal_en), .slow_crystal_en(), .fast_rc_en(fast_rc_en),
    .slow_rc_en(slow_rc_en), .pll_en(pll_en), .pll_src_rc(), .sys_clk_out(sys_clk_out),
    .tick_clk_out(tick_clk_out),
    .clk_fail_irq(clk_fail_irq));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  // Write, then read the same place back with no gap
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic wait_stable(input logic exp);
    for (int i = 0; i < 20; i++) begin
      rd(sclk_pkg::OFF_OSC_STS, v);
      if (v[0] === exp) break;
    end
    check("stable", {31'h0, v[0]}, {31'h0, exp});
    if (v[0] !== exp) print_verdict();
  endtask
  // Crystal stops while selected; fail is seen and the block falls back
  task automatic fail_run(input logic irq_on, input logic [31:0] sel);
    wait_stable(1'b1);
    wr(sclk_pkg::OFF_CLK_SEL0, sel, v);
    stop_fast <= 1'b1;
    for (int i = 0; i < 60 && clk_fail_irq !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check("irq", {31'h0, clk_fail_irq}, {31'h0, irq_on});
    if (irq_on && clk_fail_irq !== 1'b1) print_verdict();
    rd(sclk_pkg::OFF_DET_STS, v);
    check("status", v, 32'h0000_0001);
    rd(sclk_pkg::OFF_CLK_SEL0, v);
    check("auto select", v, 32'h0000_003F);
    check("irq cleared", {31'h0, clk_fail_irq}, 32'h0000_0000);
    wait_stable(1'b0);
    check("mux source", {29'h0, v[6:4]}, 32'h0000_0007);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(sclk_pkg::OFF_CLK_SEL0, v);
    check("select reset", v, sclk_pkg::RST_CLK_SEL0);
    rd(sclk_pkg::OFF_TICK_CSR, v);
    check("tick reset", v, sclk_pkg::RST_TICK_CSR);
    wr(sclk_pkg::OFF_TICK_CSR, 32'h0000_0000, v);
    check("tick ext", v, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      wr(sclk_pkg::OFF_CLK_SEL0, ROWS[i][0], v);
      check("select", v, ROWS[i][1]);
    end
    rd(8'h40, v);
    check("unmapped", v, 32'h0000_0000);
    wr(sclk_pkg::OFF_TICK_CSR, 32'h0000_0004, v);
    wr(sclk_pkg::OFF_OSC_CTL, 32'h0000_0001, v);
    wr(sclk_pkg::OFF_DET_CTL, 32'h0000_3030, v);
    check("fast rc", {31'h0, fast_rc_en}, 32'h0000_0001);
    check("slow rc", {31'h0, slow_rc_en}, 32'h0000_0001);
    fail_run(1'b1, 32'h0000_0038);
    // Retry: crystal off, then on again with the interrupt masked
    wr(sclk_pkg::OFF_OSC_CTL, 32'h0000_0000, v);
    check("crystal en", {31'h0, fast_crystal_en}, 32'h0000_0000);
    wr(sclk_pkg::OFF_DET_CTL, 32'h0000_0010, v);
    stop_fast <= 1'b0;
    wr(sclk_pkg::OFF_OSC_CTL, 32'h0000_0001, v);
    fail_run(1'b0, 32'h0000_0038);
    // Crystal behind the PLL fails as well
    stop_fast <= 1'b0;
    wr(sclk_pkg::OFF_OSC_CTL, 32'h0000_0000, v);
    wr(sclk_pkg::OFF_OSC_CTL, 32'h0000_0011, v);
    check("pll en", {30'h0, fast_crystal_en, pll_en}, 32'h0000_0003);
    fail_run(1'b0, 32'h0000_003A);
    // Reset in mid-run
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(sclk_pkg::OFF_CLK_SEL0, v);
    check("select after reset", v, sclk_pkg::RST_CLK_SEL0);
    check("rc after reset", {31'h0, fast_rc_en}, 32'h0000_0001);
    print_verdict();
  end
endmodule
